// file: rtl/tgc_pkg.sv
// Purpose : shared constants and carriers for the trace gate control block
// Assumes : 32-bit avalon-mm register port, one clock
// Notes   : offsets are byte addresses, one aligned word per register

package tgc_pkg;

   // -------------------------------------------------------------------
   // sizes
   // -------------------------------------------------------------------
   localparam int TGC_NSAC = 16;
   localparam int TGC_NARC = 8;
   localparam int TGC_NWP  = 8;
   localparam int TGC_AW   = 32;
   localparam int TGC_DW   = 32;
   localparam int TGC_BAW  = 6;

   // -------------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------------
   localparam logic [TGC_BAW-1:0] TGC_OFS_CTRL  = 6'h00;
   localparam logic [TGC_BAW-1:0] TGC_OFS_SSSEL = 6'h04;
   localparam logic [TGC_BAW-1:0] TGC_OFS_WPSEL = 6'h08;
   localparam logic [TGC_BAW-1:0] TGC_OFS_EVT   = 6'h0C;
   localparam logic [TGC_BAW-1:0] TGC_OFS_RNG   = 6'h10;
   localparam logic [TGC_BAW-1:0] TGC_OFS_STAT  = 6'h14;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int TGC_B_HOLD  = 0;
   localparam int TGC_B_EXCL  = 1;
   localparam int TGC_B_SSEN  = 2;
   localparam int TGC_B_LOCK  = 3;
   localparam int TGC_B_EVUSE = 0;
   localparam int TGC_STOP_LSB = 16;
   localparam int TGC_S_GATE  = 0;
   localparam int TGC_S_LATCH = 1;
   localparam int TGC_S_INHIB = 2;
   localparam int TGC_S_KILL  = 3;
   localparam int TGC_S_WSTA  = 4;
   localparam int TGC_S_WSTO  = 5;

   // -------------------------------------------------------------------
   // reset values
   // -------------------------------------------------------------------
   localparam logic [TGC_DW-1:0] TGC_CTRL_RST = 32'h0000_0001;
   localparam logic [TGC_DW-1:0] TGC_ZERO     = 32'h0000_0000;

   // -------------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------------
   typedef struct packed {
      logic              waypoint;
      logic              bytecode;
      logic              dbg_halt;
      logic              prohibit;
      logic              power_down;
      logic              enable_event;
      logic [TGC_AW-1:0] dest_addr;
   } tgc_core_t;

   typedef struct packed {
      logic              gate;
      logic              block_trace;
      logic              isync;
      logic              latch;
      logic [TGC_AW-1:0] isync_addr;
   } tgc_trace_t;

endpackage

// file: rtl/tgc_blk_acc.sv
// Purpose : gathers start and stop hits seen anywhere inside one block
// Assumes : i_close marks the waypoint that ends the block
// Notes   : a hit in the closing cycle still counts for the closing block

`timescale 1ns/1ps
`default_nettype none

module tgc_blk_acc #(
   parameter int W = 8
) (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic [W-1:0] i_hit,
   input  wire logic [W-1:0] i_sel_start,
   input  wire logic [W-1:0] i_sel_stop,
   input  wire logic         i_close,
   output logic              o_start,
   output logic              o_stop,
   output logic              o_pend_start,
   output logic              o_pend_stop
);

   logic start_ff;
   logic stop_ff;
   logic now_start;
   logic now_stop;

   assign now_start = |(i_hit & i_sel_start);
   assign now_stop  = |(i_hit & i_sel_stop);

   // many hits in one block collapse into one start and one stop
   assign o_start = start_ff | now_start;
   assign o_stop  = stop_ff | now_stop;
   assign o_pend_start = start_ff;
   assign o_pend_stop  = stop_ff;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         start_ff <= 1'b0;
      end else if (i_close) begin
         start_ff <= 1'b0;
      end else if (now_start) begin
         start_ff <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         stop_ff <= 1'b0;
      end else if (i_close) begin
         stop_ff <= 1'b0;
      end else if (now_stop) begin
         stop_ff <= 1'b1;
      end
   end

endmodule // tgc_blk_acc

`default_nettype wire

// file: rtl/tgc_trace_gate.sv
// Purpose : trace gate control, decides per waypoint block whether to trace
// Assumes : core signals share i_clk; comparator hits valid at waypoint
// Notes   : registers over avalon-mm, one wait state per access
//
// Operation
// - gate activation between waypoints takes effect at the next waypoint.
// - on gate rising, emit sync pulse carrying the traced block start address.
// - no start while hold bit set, bytecode state, debug halt or prohibited.
// - gate drops only at a waypoint, except on a kill, so blocks are whole unless killed.
// - hold bit, save-restore lock or power down stop trace at once.
// - any traced instruction in a block means the whole block is traced.
// - latch set by selected start, held until selected stop; enables gate.
// - start and stop chosen per address match and per watchpoint input.
// - address stop keeps latch on for that block, clears at waypoint.
// - one to eight watchpoint inputs, driven by processor range outputs.
// - a block holding a start point is traced.
// - stop block traced; next block untraced unless it holds a new start.
// - start and stop in one block: on for block, off afterwards.
// - several starts act as one start, several stops as one stop.
// - include mode traces blocks touching any selected range.
// - exclude mode drops a block only if a selected range covers it.
// - only event-driven or context-linked changes may be imprecise.
// - address matches are evaluated only at waypoints.
// - trace needs event, latch on or unused, and range condition met.
// - latch output always available as a resource.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.

`timescale 1ns/1ps
`default_nettype none

module tgc_trace_gate
   import tgc_pkg::*;
#(
   parameter int NSAC = tgc_pkg::TGC_NSAC,
   parameter int NARC = tgc_pkg::TGC_NARC,
   parameter int NWP  = tgc_pkg::TGC_NWP
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_sys_rst,
   input  wire logic [tgc_pkg::TGC_BAW-1:0] i_avs_address,
   input  wire logic                       i_avs_read,
   input  wire logic                       i_avs_write,
   input  wire logic [tgc_pkg::TGC_DW-1:0] i_avs_writedata,
   input  wire logic [3:0]                 i_avs_byteenable,
   output logic      [tgc_pkg::TGC_DW-1:0] o_avs_readdata,
   output logic                            o_avs_waitrequest,
   input  wire tgc_pkg::tgc_core_t         i_core,
   input  wire logic [NSAC-1:0]            i_single_addr_match,
   input  wire logic [NARC-1:0]            i_addr_range_match,
   input  wire logic [NARC-1:0]            i_addr_range_cover,
   input  wire logic [NWP-1:0]             i_watchpoint_range_out,
   output tgc_pkg::tgc_trace_t             o_trace
);

   // -------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------
   function automatic logic [TGC_DW-1:0] be_merge(
      input logic [TGC_DW-1:0] old_v,
      input logic [TGC_DW-1:0] new_v,
      input logic [3:0]        be
   );
      logic [TGC_DW-1:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_reg(
      input logic [TGC_BAW-1:0] a,
      input logic [TGC_BAW-1:0] ofs
   );
      return a == ofs;
   endfunction

   // -------------------------------------------------------------------
   // register port
   // -------------------------------------------------------------------
   logic              ack_ff;
   logic              req;
   logic              wr_now;
   logic [TGC_DW-1:0] rd_ff;
   logic [TGC_DW-1:0] nxt_rd;
   logic [TGC_DW-1:0] trace_gate_control_reg_ff;
   logic [TGC_DW-1:0] startstop_select_reg_ff;
   logic [TGC_DW-1:0] watchpoint_startstop_select_reg_ff;
   logic [TGC_DW-1:0] trace_gate_event_reg_ff;
   logic [TGC_DW-1:0] range_select_reg_ff;
   logic [TGC_DW-1:0] status_word;

   // one wait state: the answer is ready at the second edge
   assign req               = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_ff;
   assign wr_now            = i_avs_write & ack_ff;
   assign o_avs_readdata    = rd_ff;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   always_comb begin
      nxt_rd = TGC_ZERO;
      unique case (1'b1)
         is_reg(i_avs_address, TGC_OFS_CTRL):
            nxt_rd = trace_gate_control_reg_ff;
         is_reg(i_avs_address, TGC_OFS_SSSEL):
            nxt_rd = startstop_select_reg_ff;
         is_reg(i_avs_address, TGC_OFS_WPSEL):
            nxt_rd = watchpoint_startstop_select_reg_ff;
         is_reg(i_avs_address, TGC_OFS_EVT):
            nxt_rd = trace_gate_event_reg_ff;
         is_reg(i_avs_address, TGC_OFS_RNG):
            nxt_rd = range_select_reg_ff;
         is_reg(i_avs_address, TGC_OFS_STAT):
            nxt_rd = status_word;
         default:
            nxt_rd = TGC_ZERO;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rd_ff <= TGC_ZERO;
      end else if (i_avs_read & ~ack_ff) begin
         rd_ff <= nxt_rd;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         trace_gate_control_reg_ff <= TGC_CTRL_RST;
      end else if (wr_now & is_reg(i_avs_address, TGC_OFS_CTRL)) begin
         trace_gate_control_reg_ff <= be_merge(trace_gate_control_reg_ff,
            i_avs_writedata, i_avs_byteenable);
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         startstop_select_reg_ff <= TGC_ZERO;
      end else if (wr_now & is_reg(i_avs_address, TGC_OFS_SSSEL)) begin
         startstop_select_reg_ff <= be_merge(startstop_select_reg_ff,
            i_avs_writedata, i_avs_byteenable);
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         watchpoint_startstop_select_reg_ff <= TGC_ZERO;
      end else if (wr_now & is_reg(i_avs_address, TGC_OFS_WPSEL)) begin
         watchpoint_startstop_select_reg_ff <= be_merge(
            watchpoint_startstop_select_reg_ff,
            i_avs_writedata, i_avs_byteenable);
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         trace_gate_event_reg_ff <= TGC_ZERO;
      end else if (wr_now & is_reg(i_avs_address, TGC_OFS_EVT)) begin
         trace_gate_event_reg_ff <= be_merge(trace_gate_event_reg_ff,
            i_avs_writedata, i_avs_byteenable);
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         range_select_reg_ff <= TGC_ZERO;
      end else if (wr_now & is_reg(i_avs_address, TGC_OFS_RNG)) begin
         range_select_reg_ff <= be_merge(range_select_reg_ff,
            i_avs_writedata, i_avs_byteenable);
      end
   end

   // -------------------------------------------------------------------
   // control fields
   // -------------------------------------------------------------------
   logic            programming_hold_bit;
   logic            excl_mode;
   logic            ss_en;
   logic            save_restore_lock;
   logic            ev_use;
   logic [NSAC-1:0] sam_start_sel;
   logic [NSAC-1:0] sam_stop_sel;
   logic [NWP-1:0]  wp_start_sel;
   logic [NWP-1:0]  wp_stop_sel;
   logic [NARC-1:0] rng_sel;

   assign programming_hold_bit = trace_gate_control_reg_ff[TGC_B_HOLD];
   assign excl_mode         = trace_gate_control_reg_ff[TGC_B_EXCL];
   assign ss_en             = trace_gate_control_reg_ff[TGC_B_SSEN];
   assign save_restore_lock = trace_gate_control_reg_ff[TGC_B_LOCK];
   assign ev_use            = trace_gate_event_reg_ff[TGC_B_EVUSE];
   assign sam_start_sel = startstop_select_reg_ff[NSAC-1:0];
   assign sam_stop_sel  =
      startstop_select_reg_ff[TGC_STOP_LSB +: NSAC];
   assign wp_start_sel  = watchpoint_startstop_select_reg_ff[NWP-1:0];
   assign wp_stop_sel   =
      watchpoint_startstop_select_reg_ff[TGC_STOP_LSB +: NWP];
   assign rng_sel       = range_select_reg_ff[NARC-1:0];

   // -------------------------------------------------------------------
   // start / stop gathering per block
   // -------------------------------------------------------------------
   logic wpt;
   logic wp_start;
   logic wp_stop;
   logic wp_pend_start;
   logic wp_pend_stop;
   logic blk_start;
   logic blk_stop;

   assign wpt = i_core.waypoint;

   // watchpoints may fire mid-block, so they are held until the waypoint
   tgc_blk_acc #(
      .W (NWP)
   ) u_wp_acc (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_hit        (i_watchpoint_range_out),
      .i_sel_start  (wp_start_sel),
      .i_sel_stop   (wp_stop_sel),
      .i_close      (wpt),
      .o_start      (wp_start),
      .o_stop       (wp_stop),
      .o_pend_start (wp_pend_start),
      .o_pend_stop  (wp_pend_stop)
   );

   // address matches are only looked at in the waypoint cycle
   assign blk_start = wp_start | |(i_single_addr_match & sam_start_sel);
   assign blk_stop  = wp_stop | |(i_single_addr_match & sam_stop_sel);

   // -------------------------------------------------------------------
   // start / stop latch
   // -------------------------------------------------------------------
   logic latch_ff;
   logic nxt_latch;

   always_comb begin
      nxt_latch = latch_ff;
      if (wpt) begin
         if (blk_stop) begin
            nxt_latch = 1'b0;
         end else if (blk_start) begin
            nxt_latch = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         latch_ff <= 1'b0;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   // -------------------------------------------------------------------
   // gate decision
   // -------------------------------------------------------------------
   logic ev_seen_ff;
   logic ev_term;
   logic ss_term;
   logic rng_term;
   logic inhibit;
   logic kill;
   logic want;

   // an event seen anywhere in the block counts at its closing waypoint
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ev_seen_ff <= 1'b0;
      end else if (wpt) begin
         ev_seen_ff <= 1'b0;
      end else if (i_core.enable_event) begin
         ev_seen_ff <= 1'b1;
      end
   end

   assign ev_term = ~ev_use | ev_seen_ff | i_core.enable_event;
   // stop block itself is traced; start block traced too
   assign ss_term = ~ss_en | latch_ff | blk_start;
   // one mode bit serves every selected range
   assign rng_term = excl_mode
      ? ~|(i_addr_range_cover & rng_sel)
      :  |(i_addr_range_match & rng_sel);
   assign inhibit = programming_hold_bit | i_core.bytecode
      | i_core.dbg_halt | i_core.prohibit;
   assign kill = programming_hold_bit | save_restore_lock
      | i_core.power_down;
   assign want = ev_term & ss_term & rng_term;

   // -------------------------------------------------------------------
   // gate and trace outputs
   // -------------------------------------------------------------------
   logic              gate_ff;
   logic              nxt_gate;
   logic              blk_ff;
   logic              isync_ff;
   logic [TGC_AW-1:0] last_dest_ff;
   logic [TGC_AW-1:0] isync_addr_ff;

   always_comb begin
      nxt_gate = gate_ff;
      if (kill) begin
         nxt_gate = 1'b0;
      end else if (wpt) begin
         nxt_gate = want & ~inhibit;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         gate_ff <= 1'b0;
      end else begin
         gate_ff <= nxt_gate;
      end
   end

   // whole block reported traced at its closing waypoint
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         blk_ff <= 1'b0;
      end else begin
         blk_ff <= wpt & want & ~inhibit & ~kill;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         isync_ff <= 1'b0;
      end else begin
         isync_ff <= wpt & ~gate_ff & nxt_gate;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         isync_addr_ff <= TGC_ZERO;
      end else if (wpt & ~gate_ff & nxt_gate) begin
         isync_addr_ff <= last_dest_ff;
      end
   end

   // block start address is the previous waypoint's destination
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         last_dest_ff <= TGC_ZERO;
      end else if (wpt) begin
         last_dest_ff <= i_core.dest_addr;
      end
   end

   assign o_trace.gate        = gate_ff;
   assign o_trace.block_trace = blk_ff;
   assign o_trace.isync       = isync_ff;
   assign o_trace.latch       = latch_ff;
   assign o_trace.isync_addr  = isync_addr_ff;

   // -------------------------------------------------------------------
   // status readback
   // -------------------------------------------------------------------
   always_comb begin
      status_word              = TGC_ZERO;
      status_word[TGC_S_GATE]  = gate_ff;
      status_word[TGC_S_LATCH] = latch_ff;
      status_word[TGC_S_INHIB] = inhibit;
      status_word[TGC_S_KILL]  = kill;
      status_word[TGC_S_WSTA]  = wp_pend_start;
      status_word[TGC_S_WSTO]  = wp_pend_stop;
   end

endmodule // tgc_trace_gate

`default_nettype wire

// file: test/tgc_trace_gate_sva.sv
// Purpose : port-level checks on the trace gate control block
// Assumes : one clock, async active-high reset
// Notes   : register kills seen only through completed ctrl writes
`timescale 1ns/1ps
`default_nettype none

module tgc_trace_gate_sva (
   input wire logic                        i_clk,
   input wire logic                        i_sys_rst,
   input wire logic [tgc_pkg::TGC_BAW-1:0] i_avs_address,
   input wire logic                        i_avs_read,
   input wire logic                        i_avs_write,
   input wire logic                        o_avs_waitrequest,
   input wire tgc_pkg::tgc_core_t          i_core,
   input wire tgc_pkg::tgc_trace_t         o_trace
);
   import tgc_pkg::*;
   // hold bit and lock live in registers, so a completed ctrl write
   // is the only visible cause of a kill from the bus side
   logic wr_ctrl;
   assign wr_ctrl = i_avs_write & ~o_avs_waitrequest &
                    (i_avs_address == TGC_OFS_CTRL);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   a_gate_rise: assert property (
      $rose(o_trace.gate) |-> $past(i_core.waypoint))
      else $error("gate rose off a waypoint");
   a_gate_fall: assert property (
      $fell(o_trace.gate) |-> $past(i_core.waypoint) ||
      $past(i_core.power_down) || $past(wr_ctrl) || $past(wr_ctrl, 2) ||
      $past(wr_ctrl, 3))
      else $error("gate fell without waypoint or kill");
   a_isync_rise: assert property (
      o_trace.isync |-> $rose(o_trace.gate))
      else $error("sync pulse without gate rise");
   a_rise_isync: assert property (
      $rose(o_trace.gate) |-> o_trace.isync && o_trace.block_trace)
      else $error("gate rise without sync and block pulse");
   a_block_wp: assert property (
      o_trace.block_trace |-> $past(i_core.waypoint) && o_trace.gate)
      else $error("block pulse off a waypoint");
   a_no_inhibit: assert property (
      $rose(o_trace.gate) |->
      !$past(i_core.bytecode || i_core.dbg_halt || i_core.prohibit))
      else $error("gate rose while inhibited");
   a_pd_kill: assert property (
      i_core.power_down |=> !o_trace.gate)
      else $error("gate kept through power down");
   a_latch_fall: assert property (
      $fell(o_trace.latch) |-> $past(i_core.waypoint))
      else $error("latch cleared off a waypoint");
   a_rst_off: assert property (
      $fell(i_sys_rst) |-> !o_trace.gate && !o_trace.latch && !o_trace.isync)
      else $error("trace state not off after reset");
   a_wait_first: assert property (
      (i_avs_read || i_avs_write) && !$past(i_avs_read || i_avs_write)
      |-> o_avs_waitrequest)
      else $error("new request not held off");
   a_wait_one: assert property (
      o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("more than one wait state");

   c_isync: cover property (o_trace.isync);
   c_kill: cover property ($fell(o_trace.gate) && !$past(i_core.waypoint));
   c_latch_off: cover property ($fell(o_trace.latch));
endmodule // tgc_trace_gate_sva

bind tgc_trace_gate tgc_trace_gate_sva chk_u (
   .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest), .i_core(i_core),
   .o_trace(o_trace));

`default_nettype wire

// file: test/tgc_core_model.sv
// Purpose : processor core model feeding waypoints and comparator hits
// Assumes : bench calls the tasks, one waypoint per blk call
// Notes   : comparator lines carry garbage between waypoints
`timescale 1ns/1ps
`default_nettype none

module tgc_core_model (
   input  wire logic              i_clk,
   output var tgc_pkg::tgc_core_t o_core,
   output var logic [15:0]        o_sam,
   output var logic [7:0]         o_rhit,
   output var logic [7:0]         o_rcov,
   output var logic [7:0]         o_wp
);
   import tgc_pkg::*;
   int unsigned nwp = 0;
   initial begin
      o_core = '0;
      o_sam = '0;
      o_rhit = '0;
      o_rcov = '0;
      o_wp = '0;
   end
   // {bytecode, dbg_halt, prohibit, power_down, enable_event}
   task automatic lvl(input logic [4:0] v);
      @(posedge i_clk);
      {o_core.bytecode, o_core.dbg_halt, o_core.prohibit,
       o_core.power_down, o_core.enable_event} <= v;
   endtask
   task automatic blk(input logic [15:0] s, input logic [7:0] m,
                      input logic [7:0] c);
      @(posedge i_clk);
      nwp++;
      o_core.waypoint <= 1'b1;
      o_core.dest_addr <= 32'(nwp) << 8;
      o_sam <= s;
      o_rhit <= m;
      o_rcov <= c;
      @(posedge i_clk);
      o_core.waypoint <= 1'b0;
      // inverse of the hit, so off-waypoint sampling shows up
      o_sam <= ~s;
      o_rhit <= ~m;
      o_rcov <= ~c;
   endtask
   task automatic wpt(input logic [7:0] w);
      @(posedge i_clk);
      o_wp <= w;
      @(posedge i_clk);
      o_wp <= 8'h00;
   endtask
endmodule // tgc_core_model

`default_nettype wire

// file: test/trace_gate_control_bench.sv
// Purpose : self-checking bench for the trace gate control block
// Assumes : core model drives waypoints, avalon master in this bench
// Notes   : gate and sync sampled 1 ns after the waypoint edge
`timescale 1ns/1ps
`default_nettype none

module trace_gate_control_bench;
   import tgc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [5:0]  adr = 6'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic [31:0] q;
   logic        wreq;
   tgc_core_t   core;
   tgc_trace_t  tr;
   logic [15:0] sam;
   logic [7:0]  rhit, rcov, wp;
   logic [3:0]  be = 4'hF;
   int          mismatches = 0;
   int          checks_done = 0;
   int          cyc = 0;
   always #10 clk = ~clk;
   tgc_core_model core_u (.i_clk(clk), .o_core(core), .o_sam(sam),
      .o_rhit(rhit), .o_rcov(rcov), .o_wp(wp));
   tgc_trace_gate dut_u (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
      .i_avs_byteenable(be), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_core(core), .i_single_addr_match(sam),
      .i_addr_range_match(rhit), .i_addr_range_cover(rcov),
      .i_watchpoint_range_out(wp), .o_trace(tr));
   // the run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wreg(input logic [5:0] a, input logic [31:0] d);
      acc(1'b1, a, d);
   endtask
   task automatic rchk(input string nm, input logic [5:0] a,
                       input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      chk(nm, q, e);
   endtask
   task automatic wpc(input string nm, input logic [15:0] s,
                      input logic [7:0] m, input logic [7:0] c,
                      input logic [1:0] e);
      core_u.blk(s, m, c);
      #1;
      chk(nm, 32'({tr.gate, tr.isync}), 32'(e));
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rchk("ctrl_rst", TGC_OFS_CTRL, TGC_CTRL_RST);
      rchk("stat_rst", TGC_OFS_STAT, 32'h0000_000C);
      wreg(6'h18, 32'hFFFF_FFFF);
      rchk("unmapped", 6'h18, TGC_ZERO);
      be <= 4'h2;
      wreg(TGC_OFS_SSSEL, 32'hFFFF_FFFF);
      be <= 4'hF;
      rchk("be_lane", TGC_OFS_SSSEL, 32'h0000_FF00);
      wreg(TGC_OFS_SSSEL, 32'h0006_0001);
      wreg(TGC_OFS_WPSEL, 32'h0002_0001);
      wreg(TGC_OFS_CTRL, 32'h0000_0007);
      wpc("hold", 16'h0003, 8'h00, 8'h00, 2'h0);
      wreg(TGC_OFS_CTRL, 32'h0000_0006);
      $display("test reset done");
      wpc("both", 16'h0003, 8'h00, 8'h00, 2'h3);
      wpc("both_after", 16'h0000, 8'h00, 8'h00, 2'h0);
      wpc("start", 16'h0001, 8'h00, 8'h00, 2'h3);
      chk("sync_addr", tr.isync_addr, 32'(core_u.nwp - 1) << 8);
      rchk("stat_on", TGC_OFS_STAT, 32'h0000_0003);
      wpc("held", 16'h0000, 8'h00, 8'h00, 2'h2);
      wpc("stops", 16'h0006, 8'h00, 8'h00, 2'h2);
      wpc("stopped", 16'h0000, 8'h00, 8'h00, 2'h0);
      core_u.wpt(8'h01);
      #1;
      chk("wp_early", 32'(tr.gate), 32'h0);
      rchk("stat_wsta", TGC_OFS_STAT, 32'h0000_0010);
      wpc("wp_start", 16'h0000, 8'h00, 8'h00, 2'h3);
      core_u.wpt(8'h02);
      wpc("wp_stop", 16'h0000, 8'h00, 8'h00, 2'h2);
      wpc("wp_off", 16'h0000, 8'h00, 8'h00, 2'h0);
      $display("test latch done");
      for (int k = 0; k < 3; k++) begin
         core_u.lvl(5'h10 >> k);
         wpc("inhibit", 16'h0003, 8'h00, 8'h00, 2'h0);
      end
      core_u.lvl(5'h00);
      for (int k = 0; k < 3; k++) begin
         wpc("kill_on", 16'h0001, 8'h00, 8'h00, 2'h3);
         if (k == 0) core_u.lvl(5'h02);
         else wreg(TGC_OFS_CTRL, (k == 1) ? 32'h0000_000E : 32'h0000_0007);
         repeat (2) @(posedge clk);
         #1;
         chk("kill", 32'(tr.gate), 32'h0);
         core_u.lvl(5'h00);
         wreg(TGC_OFS_CTRL, 32'h0000_0006);
         wpc("kill_stop", 16'h0002, 8'h00, 8'h00, 2'h3);
         wpc("kill_off", 16'h0000, 8'h00, 8'h00, 2'h0);
      end
      $display("test inhibit and kill done");
      wreg(TGC_OFS_RNG, 32'h0000_0001);
      wreg(TGC_OFS_CTRL, 32'h0000_0000);
      wpc("inc_hit", 16'h0000, 8'h01, 8'h00, 2'h3);
      wpc("inc_other", 16'h0000, 8'h02, 8'h00, 2'h0);
      wreg(TGC_OFS_CTRL, 32'h0000_0002);
      wpc("exc_part", 16'h0000, 8'h01, 8'h00, 2'h3);
      wpc("exc_cover", 16'h0000, 8'h01, 8'h01, 2'h0);
      wpc("exc_other", 16'h0000, 8'h02, 8'h02, 2'h3);
      wreg(TGC_OFS_EVT, 32'h0000_0001);
      wpc("ev_off", 16'h0000, 8'h00, 8'h00, 2'h0);
      core_u.lvl(5'h01);
      wpc("ev_on", 16'h0000, 8'h00, 8'h00, 2'h3);
      $display("test range and event done");
      final_report();
   end
endmodule // trace_gate_control_bench

`default_nettype wire
